// ### rtl/ltc_regs.vh
// Register map constants for one lane's configuration group.
// Assumes inclusion by the lane register bank and its detect timer.
`ifndef LTC_REGS_VH
`define LTC_REGS_VH

// ------------------------------------------------------------
// Offsets
// ------------------------------------------------------------
`define LTC_OFS_QUIET_DET    8'h1c
`define LTC_OFS_BOOST        8'h1d
`define LTC_OFS_SWING        8'h1e
`define LTC_OFS_EMPH         8'h1f
`define LTC_OFS_THRESH       8'h20
`define LTC_OFS_GAP          8'h21
`define LTC_OFS_FORCE        8'h22

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LTC_RST_QUIET_DET    8'h00
`define LTC_RST_BOOST        8'h2f
`define LTC_RST_SWING        8'had
`define LTC_RST_EMPH_CTL     3'h2
`define LTC_RST_THRESH       4'h0
`define LTC_RST_FORCE        2'h0

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LTC_QUIET_OVR_BIT    5
`define LTC_QUIET_SEL_BIT    4
`define LTC_POLICY_HI        3
`define LTC_POLICY_LO        2
`define LTC_SCP_BIT          7
`define LTC_RATE_BIT         6
`define LTC_SWING_RSV_HI     5
`define LTC_SWING_RSV_LO     3
`define LTC_SWING_HI         2
`define LTC_EMPH_HI          2
`define LTC_FORCE_OFF_BIT    2
`define LTC_FORCE_ON_BIT     1
`define LTC_QUIET_RW_MASK    8'h3c
`define LTC_EMPH_RW_MASK     8'h1f

// ------------------------------------------------------------
// Detect policy codes
// ------------------------------------------------------------
`define LTC_POL_OPEN         2'h0
`define LTC_POL_LIMITED      2'h1
`define LTC_POL_ENDLESS      2'h2
`define LTC_POL_FIXED        2'h3

// ------------------------------------------------------------
// Detect timing
// ------------------------------------------------------------
`define LTC_CLK_HZ           25000000
`define LTC_PROBE_MS         12
`define LTC_PROBE_LIMIT      50
`define LTC_PROBE_CYCLES     ((`LTC_CLK_HZ / 1000) * `LTC_PROBE_MS)

`endif

// ### rtl/ltc_detect_timer.v
// Far-end detection sequencer for one lane.
// Assumes the analog side returns probe_result while probe_pulse is high.
`include "ltc_regs.vh"

module ltc_detect_timer #(
   parameter PERIOD_CYCLES = `LTC_PROBE_CYCLES,
   parameter PROBE_LIMIT   = `LTC_PROBE_LIMIT
) (
   // Clock and reset
   input  wire       clock,
   input  wire       reset_n,
   // Policy
   input  wire [1:0] policy,
   // Analog probe
   input  wire       probe_result,
   output reg        probe_pulse,
   // Outcome
   output reg        found,
   output reg        term_on
);

   reg  [23:0] tick_reg;
   reg  [7:0]  tries_reg;
   reg  [1:0]  policy_reg;
   wire        tick_done = (tick_reg == PERIOD_CYCLES - 1);
   wire        may_probe = (policy == `LTC_POL_ENDLESS) ||
                           (policy == `LTC_POL_LIMITED && tries_reg < PROBE_LIMIT);

   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_reg    <= 24'h000000;
         tries_reg   <= 8'h00;
         policy_reg  <= 2'h0;
         probe_pulse <= 1'b0;
         found       <= 1'b0;
         term_on     <= 1'b0;
      end else begin
         policy_reg  <= policy;
         probe_pulse <= 1'b0;
         // A policy change restarts the search from scratch
         if (policy != policy_reg) begin
            tick_reg  <= 24'h000000;
            tries_reg <= 8'h00;
            found     <= 1'b0;
         end else if (!found && may_probe) begin
            if (tick_done) begin
               tick_reg    <= 24'h000000;
               tries_reg   <= tries_reg + 8'h01;
               probe_pulse <= 1'b1;
            end else begin
               tick_reg <= tick_reg + 24'h000001;
            end
         end
         if (probe_pulse && probe_result && policy == policy_reg &&
             (policy == `LTC_POL_LIMITED || policy == `LTC_POL_ENDLESS))
            found <= 1'b1;
         case (policy)
            `LTC_POL_OPEN:    term_on <= 1'b0;
            `LTC_POL_FIXED:   term_on <= 1'b1;
            default:          term_on <= found;
         endcase
      end
   end

endmodule // ltc_detect_timer

// ### rtl/ltc_lane_regs.v
// Configuration and status registers for one lane of a serial redriver.
// Assumes a byte-wide register port from the management slave and an
// EEPROM loader that presents one offset/data pair per load strobe.
//
// Summary of operation
// - Override bit picks manual quiet, else automatic
// - Quiet select one mutes output, zero active
// - Policy 00 open, 11 fixed fifty ohm
// - Policy 01 probes every 12 ms, 50 tries
// - Policy 10 probes every 12 ms until found
// - Register policy overrides the detect pin
// - Eight-bit boost, reset 0x2f, EEPROM loadable
// - Swing bit 7 enables short-circuit protection
// - Swing bit 6 forces older rate, overrides pin
// - Three-bit swing code, default 101
// - Emphasis bit 7 reports far end found
// - Bits 6:5 report sensed rate code
// - Three-bit emphasis code, default 010
// - Assert threshold bits 3:2 override pin
// - De-assert threshold bits 1:0 override pin
// - Force-off bit holds presence inactive
// - Force-on bit holds presence active unless force-off is also set
`include "ltc_regs.vh"

module ltc_lane_regs #(
   parameter PERIOD_CYCLES = `LTC_PROBE_CYCLES,
   parameter PROBE_LIMIT   = `LTC_PROBE_LIMIT
) (
   // Clock and reset
   input  wire       clock,
   input  wire       reset_n,
   // Register port
   input  wire [7:0] reg_addr,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   output reg        reg_hit,
   // EEPROM load
   input  wire       eep_load,
   input  wire [7:0] eep_addr,
   input  wire [7:0] eep_data,
   // Analog lane status
   input  wire       auto_quiet,
   input  wire       probe_result,
   input  wire [1:0] sensed_rate_code,
   input  wire       raw_presence,
   // Lane settings
   output reg        lane_output_mute,
   output reg        input_term_on,
   output reg        probe_pulse,
   output reg  [7:0] input_boost_field,
   output reg        short_protect_en,
   output reg        force_older_rate,
   output reg  [2:0] output_swing_field,
   output reg  [2:0] emphasis_field,
   output reg  [1:0] assert_thresh,
   output reg  [1:0] deassert_thresh,
   output reg        lane_presence,
   output reg        far_end_present_flag
);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   reg  [7:0] quiet_det_reg;
   reg  [7:0] boost_reg;
   reg  [7:0] swing_reg;
   reg  [2:0] emph_reg;
   reg  [3:0] thresh_reg;
   reg  [1:0] force_reg;
   reg  [1:0] rate_seen_reg;
   wire       found;
   wire       term_on;
   wire       pulse;

   // EEPROM load has priority; a colliding host write is dropped for that cycle
   wire       wr_any  = eep_load | reg_wr;
   wire [7:0] wr_addr = eep_load ? eep_addr : reg_addr;
   wire [7:0] wr_data = eep_load ? eep_data : reg_wdata;

   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a >= `LTC_OFS_QUIET_DET) && (a <= `LTC_OFS_FORCE);
      end
   endfunction

   // ------------------------------------------------------------
   // Writes
   // ------------------------------------------------------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         quiet_det_reg <= `LTC_RST_QUIET_DET;
         boost_reg     <= `LTC_RST_BOOST;
         swing_reg     <= `LTC_RST_SWING;
         emph_reg      <= `LTC_RST_EMPH_CTL;
         thresh_reg    <= `LTC_RST_THRESH;
         force_reg     <= `LTC_RST_FORCE;
      end else if (wr_any) begin
         case (wr_addr)
            `LTC_OFS_QUIET_DET: quiet_det_reg <= wr_data & `LTC_QUIET_RW_MASK;
            `LTC_OFS_BOOST:     boost_reg     <= wr_data;
            // Reserved swing bits are stored as written; software keeps them at 101
            `LTC_OFS_SWING:     swing_reg     <= wr_data;
            `LTC_OFS_EMPH:      emph_reg      <= wr_data[`LTC_EMPH_HI:0];
            `LTC_OFS_THRESH:    thresh_reg    <= wr_data[3:0];
            `LTC_OFS_FORCE:     force_reg     <= wr_data[`LTC_FORCE_OFF_BIT:`LTC_FORCE_ON_BIT];
            default:            force_reg     <= force_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Detection sequencer
   // ------------------------------------------------------------
   ltc_detect_timer #(
      .PERIOD_CYCLES (PERIOD_CYCLES),
      .PROBE_LIMIT   (PROBE_LIMIT)
   ) u_detect (
      .clock        (clock),
      .reset_n      (reset_n),
      .policy       (quiet_det_reg[`LTC_POLICY_HI:`LTC_POLICY_LO]),
      .probe_result (probe_result),
      .probe_pulse  (pulse),
      .found        (found),
      .term_on      (term_on)
   );

   // ------------------------------------------------------------
   // Settings out, all registered
   // ------------------------------------------------------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lane_output_mute     <= 1'b0;
         input_term_on        <= 1'b0;
         probe_pulse          <= 1'b0;
         input_boost_field    <= `LTC_RST_BOOST;
         short_protect_en     <= 1'b1;
         force_older_rate     <= 1'b0;
         output_swing_field   <= 3'h5;
         emphasis_field       <= `LTC_RST_EMPH_CTL;
         assert_thresh        <= 2'h0;
         deassert_thresh      <= 2'h0;
         lane_presence        <= 1'b0;
         far_end_present_flag <= 1'b0;
         rate_seen_reg        <= 2'h0;
      end else begin
         if (quiet_det_reg[`LTC_QUIET_OVR_BIT])
            lane_output_mute <= quiet_det_reg[`LTC_QUIET_SEL_BIT];
         else
            lane_output_mute <= auto_quiet;
         input_term_on        <= term_on;
         probe_pulse          <= pulse;
         input_boost_field    <= boost_reg;
         short_protect_en     <= swing_reg[`LTC_SCP_BIT];
         force_older_rate     <= swing_reg[`LTC_RATE_BIT];
         output_swing_field   <= swing_reg[`LTC_SWING_HI:0];
         emphasis_field       <= emph_reg;
         assert_thresh        <= thresh_reg[3:2];
         deassert_thresh      <= thresh_reg[1:0];
         if (force_reg[1])
            lane_presence <= 1'b0;
         else if (force_reg[0])
            lane_presence <= 1'b1;
         else
            lane_presence <= raw_presence;
         far_end_present_flag <= found;
         rate_seen_reg        <= sensed_rate_code;
      end
   end

   // ------------------------------------------------------------
   // Reads
   // ------------------------------------------------------------
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
         reg_hit   <= 1'b0;
      end else begin
         reg_hit <= reg_rd & is_mapped(reg_addr);
         if (reg_rd) begin
            case (reg_addr)
               `LTC_OFS_QUIET_DET: reg_rdata <= quiet_det_reg;
               `LTC_OFS_BOOST:     reg_rdata <= boost_reg;
               `LTC_OFS_SWING:     reg_rdata <= swing_reg;
               `LTC_OFS_EMPH:      reg_rdata <= {found, rate_seen_reg, 2'h0, emph_reg};
               `LTC_OFS_THRESH:    reg_rdata <= {4'h0, thresh_reg};
               `LTC_OFS_FORCE:     reg_rdata <= {5'h00, force_reg, 1'b0};
               default:            reg_rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // ltc_lane_regs

// ### test/ltc_lane_props.sv
// Port checker for the lane register bank.
// Assumes it is bound onto ltc_lane_regs; one clock domain.
module ltc_lane_props (
   // Clock and reset
   input wire       clock,
   input wire       reset_n,
   // Register port and load
   input wire [7:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       reg_hit,
   input wire       eep_load,
   input wire [7:0] eep_addr,
   input wire [7:0] eep_data,
   input wire       auto_quiet,
   // Lane settings
   input wire       lane_output_mute,
   input wire       input_term_on,
   input wire       probe_pulse,
   input wire [7:0] input_boost_field,
   input wire       short_protect_en,
   input wire       force_older_rate,
   input wire [2:0] output_swing_field,
   input wire [2:0] emphasis_field,
   input wire [1:0] assert_thresh,
   input wire [1:0] deassert_thresh,
   input wire       lane_presence,
   input wire       far_end_present_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // ------------------------------------------------------------
   // Policy shadow
   // ------------------------------------------------------------
   // A load strobe drops a same-cycle register write
   wire wx = reg_wr && !eep_load;
   reg [1:0] pol_reg;
   always @(posedge clock or negedge reset_n)
      if (!reset_n) pol_reg <= 2'h0;
      else if (eep_load && eep_addr == 8'h1c) pol_reg <= eep_data[3:2];
      else if (wx && reg_addr == 8'h1c) pol_reg <= reg_wdata[3:2];
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_boost_write: assert property (wx && reg_addr == 8'h1d |-> ##2
      input_boost_field == $past(reg_wdata, 2)) else $error("boost setting wrong");
   a_swing_write: assert property (wx && reg_addr == 8'h1e |-> ##2
      {short_protect_en, force_older_rate, output_swing_field} ==
      {$past(reg_wdata[7:6], 2), $past(reg_wdata[2:0], 2)}) else $error("swing setting wrong");
   a_emph_write: assert property (wx && reg_addr == 8'h1f |-> ##2
      emphasis_field == $past(reg_wdata[2:0], 2)) else $error("emphasis setting wrong");
   a_thresh_write: assert property (wx && reg_addr == 8'h20 |-> ##2
      {assert_thresh, deassert_thresh} == $past(reg_wdata[3:0], 2)) else $error("threshold wrong");
   a_force_off: assert property (wx && reg_addr == 8'h22 && reg_wdata[2] |->
      ##2 !lane_presence) else $error("presence not forced off");
   a_force_on: assert property (wx && reg_addr == 8'h22 && reg_wdata[2:1] == 2'b01 |->
      ##2 lane_presence) else $error("presence not forced on");
   a_quiet_mute: assert property (wx && reg_addr == 8'h1c |-> ##2 lane_output_mute ==
      ($past(reg_wdata[5], 2) ? $past(reg_wdata[4], 2) : $past(auto_quiet)))
      else $error("mute decision wrong");
   a_read_decode: assert property (reg_rd |=> reg_hit ==
      ($past(reg_addr) >= 8'h1c && $past(reg_addr) <= 8'h22)) else $error("read decode wrong");
   a_status_read: assert property (reg_rd && reg_addr == 8'h1f |=>
      reg_rdata[7] == far_end_present_flag && reg_rdata[4:0] == {2'b00, emphasis_field})
      else $error("status read wrong");
   a_term_policy: assert property ((pol_reg == 2'h0 || pol_reg == 2'h3) && $stable(pol_reg)
      [*3] |-> input_term_on == pol_reg[0] && !probe_pulse) else $error("fixed policy wrong");
   c_probe: cover property (probe_pulse && !input_term_on);
   c_found: cover property (reg_rd && reg_addr == 8'h1f ##1 reg_rdata[7]);
   c_mute: cover property (lane_output_mute);
endmodule // ltc_lane_props

bind ltc_lane_regs ltc_lane_props u_props (.*);

// ### test/ltc_host.sv
// Management host model driving the lane register port.
// Assumes callers enter its tasks at or just after a rising edge.
module ltc_host (
   // Clock
   input  wire        clock,
   // Register port
   output logic [7:0] reg_addr,
   output logic       reg_wr,
   output logic       reg_rd,
   output logic [7:0] reg_wdata,
   input  wire  [7:0] reg_rdata,
   input  wire        reg_hit
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Software never sets reserved bits, and keeps swing 5:3 at 101
   function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] x);
      case (a)
         8'h1c: legal = x & 8'h3c;
         8'h1e: legal = {x[7:6], 3'b101, x[2:0]};
         8'h1f: legal = x & 8'h07;
         8'h20: legal = x & 8'h0f;
         8'h22: legal = x & 8'h06;
         default: legal = (a == 8'h1d) ? x : 8'h00;
      endcase
   endfunction
   task wr(input logic [7:0] a, input logic [7:0] x);
      reg_addr <= a;
      reg_wdata <= legal(a, x);
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] x, output logic h);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      x = reg_rdata;
      h = reg_hit;
      @(posedge clock);
   endtask
endmodule // ltc_host

// ### test/lane_two_config_regs_bench.sv
// Self-checking bench for the lane register bank.
// Assumes ltc_host as register master and a shortened detect period.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module lane_two_config_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, reset_n = 1'b0, eep_load = 1'b0, auto_quiet = 1'b0, probe_result = 1'b0;
   logic raw_presence = 1'b0, reg_wr, reg_rd, reg_hit, lane_output_mute, input_term_on;
   logic probe_pulse, short_protect_en, force_older_rate, lane_presence, far_end_present_flag;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, input_boost_field, eep_addr = 8'h00;
   logic [7:0] eep_data = 8'h00, d, v;
   logic [2:0] output_swing_field, emphasis_field;
   logic [1:0] sensed_rate_code = 2'h0, assert_thresh, deassert_thresh;
   logic [7:0] mdl [0:6] = '{8'h00, 8'h2f, 8'had, 8'h02, 8'h00, 8'h00, 8'h00};
   logic h, found = 1'b0;
   int n_fail = 0, compares = 0, cyc = 0, n_probe = 0, r;
   ltc_lane_regs #(.PERIOD_CYCLES(20), .PROBE_LIMIT(3)) dut (.*);
   ltc_host host (.*);
   always #20 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      n_probe += probe_pulse;
      if (cyc == 2000) begin
         n_fail++;
         conclude;
      end
   end
   function automatic logic [7:0] expv(int i);
      return (i == 3) ? {found, sensed_rate_code, 2'b00, mdl[3][2:0]} : mdl[i];
   endfunction
   task put(int i, logic [7:0] x);
      mdl[i] = host.legal(8'h1c + i[7:0], x);
      host.wr(8'h1c + i[7:0], x);
      #1;
      `CHK(input_boost_field, mdl[1])
      `CHK({short_protect_en, force_older_rate, output_swing_field}, {mdl[2][7:6], mdl[2][2:0]})
      `CHK({emphasis_field, assert_thresh, deassert_thresh}, {mdl[3][2:0], mdl[4][3:0]})
   endtask
   task get(int i);
      host.rd(8'h1c + i[7:0], d, h);
      `CHK({h, d}, {1'b1, expv(i)})
   endtask
   task conclude;
      $display("Compares %0d, failures %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      r = $urandom(59323);
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      `CHK({input_boost_field, short_protect_en}, {8'h2f, 1'b1})
      `CHK({force_older_rate, output_swing_field, emphasis_field}, {1'b0, 3'h5, 3'h2})
      `CHK({assert_thresh, deassert_thresh, far_end_present_flag, input_term_on}, 6'h00)
      for (int i = 0; i < 7; i++)
         get(i);
      for (int k = 0; k < 24; k++) begin
         r = $urandom % 3;
         sensed_rate_code <= (r == 2) ? 2'h3 : r[1:0];
         v = $urandom;
         put($urandom % 7, v);
         get(k % 7);
      end
      for (int a = 8'h1b; a < 8'h24; a += 8) begin
         host.rd(a[7:0], d, h);
         `CHK({h, d}, 9'h000)
      end
      v = $urandom;
      eep_addr <= 8'h1d;
      eep_data <= v;
      eep_load <= 1'b1;
      @(posedge clock);
      eep_load <= 1'b0;
      mdl[1] = v;
      get(1);
      for (int i = 0; i < 4; i++) begin
         v = $urandom;
         auto_quiet <= v[0];
         put(0, {2'b00, i[1:0], 4'h0});
         `CHK(lane_output_mute, i[1] ? i[0] : v[0])
         raw_presence <= v[1];
         put(6, {5'h00, i[1:0], 1'b0});
         `CHK(lane_presence, i[1] ? 1'b0 : (i[0] | v[1]))
      end
      put(0, 8'h04);
      n_probe = 0;
      repeat (150) @(posedge clock);
      `CHK(n_probe, 3)
      `CHK(input_term_on, 1'b0)
      // Endless policy must keep probing past the limited policy's attempt count
      put(0, 8'h08);
      n_probe = 0;
      repeat (100) @(posedge clock);
      `CHK(n_probe > 3, 1'b1)
      `CHK(input_term_on, 1'b0)
      probe_result <= 1'b1;
      repeat (30) @(posedge clock);
      found = 1'b1;
      `CHK(input_term_on, 1'b1)
      `CHK(far_end_present_flag, found)
      get(3);
      put(0, 8'h0c);
      found = 1'b0;
      repeat (4) @(posedge clock);
      `CHK(input_term_on, 1'b1)
      get(3);
      put(0, 8'h00);
      repeat (4) @(posedge clock);
      `CHK(input_term_on, 1'b0)
      conclude;
   end
endmodule // lane_two_config_regs_bench
